// ==== hw/fcp_ctrl.sv ====
/*
  Host-side controller for the control pins of a parallel flash: hard reset, protect level, bus width,
  and the shared busy line, steered through two Wishbone classic registers.
  Assumes a level detector beside the flash turns the protect level code into the three pin voltages.
*/
// Chosen here: the Wishbone register port and the placing of the registers.
`include "fcp_defs.svh"
`default_nettype none
module fcp_ctrl
  import fcp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        busy_open_drain_out_i,
  output var  logic        hard_reset_pin_n_o,
  output var  logic [1:0]  accel_voltage_level_o,
  output var  logic        width_select_o,
  output var  logic        device_ready_o
);
  localparam int RST_LOW_CYC = `FCP_MIN_CYC(`FCP_RESET_LOW_MIN_NS);
  localparam int REC_A_CYC   = `FCP_MIN_CYC(`FCP_RESET_RECOVERY_NS);
  localparam int REC_B_CYC   = `FCP_MIN_CYC(`FCP_BUSY_RELEASE_RECOVERY_NS);
  localparam int REC_CYC     = (REC_A_CYC > REC_B_CYC) ? REC_A_CYC : REC_B_CYC;
  localparam int CW          = 16;

  fcp_state_e      state_r;
  fcp_state_e      state_nxt;
  logic [CW-1:0]   cnt_r;
  logic [CW-1:0]   cnt_nxt;
  fcp_prot_e       prot_req_r;
  fcp_prot_e       prot_r;
  fcp_prot_e       prot_nxt;
  logic            wide_r;
  logic            refused_r;
  logic            refused_nxt;
  logic            ack_r;
  logic [31:0]     dat_r;
  logic            pin_n_r;
  logic            ready_r;
  logic            line_level;

  fcp_pin_sync u_busy_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (busy_open_drain_out_i),
    .level_o (line_level)
  );

  wire        line_busy  = ~line_level;
  wire        wb_req     = wb_cyc_i & wb_stb_i;
  wire        ack_nxt    = wb_req & ~ack_r;
  wire        wr_go      = wb_req & wb_we_i & ack_r & wb_sel_i[0];
  wire        hit_ctrl   = wb_adr_i == `FCP_ADR_CTRL;
  wire        hit_stat   = wb_adr_i == `FCP_ADR_STATUS;
  wire        wr_ctrl    = wr_go & hit_ctrl;
  wire        wr_stat    = wr_go & hit_stat;
  wire [1:0]  wr_prot    = wb_dat_i[`FCP_CTRL_PROT_MSB:`FCP_CTRL_PROT_LSB];
  wire        rst_req    = wr_ctrl & wb_dat_i[`FCP_CTRL_RST_REQ];
  wire        in_read    = (state_r == FCP_ST_READY) & ~line_busy;
  wire        refuse     = wr_ctrl & (wr_prot == FCP_PROT_ACCEL) & ~in_read;
  wire        cnt_end_rl = cnt_r == CW'(RST_LOW_CYC - 1);
  wire        cnt_end_rc = cnt_r == CW'(REC_CYC - 1);
  wire [31:0] stat_word  = {26'h0, refused_r, prot_r, pin_n_r == 1'h0, ready_r, line_busy};
  wire [31:0] ctrl_word  = {28'h0, wide_r, prot_req_r, 1'h0};
  wire [31:0] rd_mux     = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + CW'(1);
    case (state_r)
      FCP_ST_RESET_LOW:
      begin
        if (cnt_end_rl)
        begin
          state_nxt = FCP_ST_RECOVER;
          cnt_nxt   = '0;
        end
      end
      FCP_ST_RECOVER:
      begin
        if (cnt_end_rc)
          state_nxt = FCP_ST_WAIT_READY;
      end
      FCP_ST_WAIT_READY:
      begin
        cnt_nxt = cnt_r;
        if (!line_busy)
          state_nxt = FCP_ST_READY;
      end
      FCP_ST_READY:
        cnt_nxt = cnt_r;
      default:
        state_nxt = FCP_ST_RESET_LOW;
    endcase
    if (rst_req)
    begin
      state_nxt = FCP_ST_RESET_LOW;
      cnt_nxt   = '0;
    end
  end

  always_comb
  begin
    prot_nxt = prot_r;
    if (prot_req_r != FCP_PROT_ACCEL)
      prot_nxt = prot_req_r;
    else if (in_read)
      prot_nxt = FCP_PROT_ACCEL;
  end

  assign refused_nxt = refuse | (refused_r & ~(wr_stat & wb_dat_i[`FCP_STAT_REFUSED]));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r    <= FCP_ST_RESET_LOW;
      cnt_r      <= '0;
      prot_req_r <= FCP_PROT_HIGH;
      prot_r     <= FCP_PROT_HIGH;
      wide_r     <= `FCP_RST_WIDE;
      refused_r  <= 1'h0;
      ack_r      <= 1'h0;
      dat_r      <= 32'h0;
      pin_n_r    <= 1'h0;
      ready_r    <= 1'h0;
    end
    else
    begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      prot_r    <= prot_nxt;
      refused_r <= refused_nxt;
      ack_r     <= ack_nxt;
      pin_n_r   <= state_nxt != FCP_ST_RESET_LOW;
      ready_r   <= (state_nxt == FCP_ST_READY) & ~line_busy;
      if (ack_nxt)
        dat_r <= rd_mux;
      if (wr_ctrl)
      begin
        prot_req_r <= (wr_prot == 2'h3) ? FCP_PROT_HIGH : fcp_prot_e'(wr_prot);
        wide_r     <= wb_dat_i[`FCP_CTRL_WIDE];
      end
    end
  end

  assign wb_ack_o              = ack_r;
  assign wb_dat_o              = dat_r;
  assign hard_reset_pin_n_o    = pin_n_r;
  assign accel_voltage_level_o = prot_r;
  assign width_select_o        = wide_r;
  assign device_ready_o        = ready_r;

  logic [CW-1:0] low_len_r;
  logic [CW-1:0] since_rel_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_len_r   <= '0;
      since_rel_r <= '0;
    end
    else
    begin
      low_len_r   <= pin_n_r ? '0 : low_len_r + CW'(1);
      since_rel_r <= !pin_n_r ? '0 : ((since_rel_r == '1) ? since_rel_r : since_rel_r + CW'(1));
    end
  end

  property p_reset_low_min;
    @(posedge clk_i) disable iff (rst_i)
    $rose(pin_n_r) |-> $past(low_len_r) >= CW'(RST_LOW_CYC - 1);
  endproperty
  a_reset_low_min: assert property (p_reset_low_min) else $error("Reset pulse too short.");

  property p_recovery;
    @(posedge clk_i) disable iff (rst_i)
    $rose(ready_r) |-> since_rel_r >= CW'(REC_CYC);
  endproperty
  a_recovery: assert property (p_recovery) else $error("Ready before recovery elapsed.");

  property p_ready_needs_release;
    @(posedge clk_i) disable iff (rst_i)
    ready_r |-> $past(!line_busy) && pin_n_r;
  endproperty
  a_ready_needs_release: assert property (p_ready_needs_release) else $error("Ready while line busy.");

  property p_accel_from_read;
    @(posedge clk_i) disable iff (rst_i)
    (prot_r == FCP_PROT_ACCEL) && ($past(prot_r) != FCP_PROT_ACCEL) |-> $past(in_read);
  endproperty
  a_accel_from_read: assert property (p_accel_from_read) else $error("Accel level outside read.");

  property p_reset_request;
    @(posedge clk_i) disable iff (rst_i)
    rst_req |=> !pin_n_r [*8];
  endproperty
  a_reset_request: assert property (p_reset_request) else $error("Reset request not applied.");

  property p_leave_accel;
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl && (wr_prot == FCP_PROT_LOW) |-> ##2 prot_r == FCP_PROT_LOW;
  endproperty
  a_leave_accel: assert property (p_leave_accel) else $error("Low level not applied.");

  property p_width;
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> width_select_o == $past(wb_dat_i[`FCP_CTRL_WIDE]);
  endproperty
  a_width: assert property (p_width) else $error("Width select not updated.");

  property p_refused_flag;
    @(posedge clk_i) disable iff (rst_i)
    refuse |=> refused_r && (prot_r != FCP_PROT_ACCEL);
  endproperty
  a_refused_flag: assert property (p_refused_flag) else $error("Refusal not flagged.");

  property p_busy_status;
    @(posedge clk_i) disable iff (rst_i)
    ack_nxt && !wb_we_i && hit_stat |=> wb_dat_o[`FCP_STAT_BUSY] == $past(line_busy);
  endproperty
  a_busy_status: assert property (p_busy_status) else $error("Busy status wrong.");

  property p_ack_single;
    @(posedge clk_i) disable iff (rst_i)
    ack_r |=> !ack_r;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("Ack longer than one cycle.");

  c_reset_done: cover property (@(posedge clk_i) disable iff (rst_i) $rose(ready_r));
  c_accel: cover property (@(posedge clk_i) disable iff (rst_i) $rose(prot_r == FCP_PROT_ACCEL));
  c_refused: cover property (@(posedge clk_i) disable iff (rst_i) refuse);
endmodule // fcp_ctrl
`default_nettype wire

// ==== hw/fcp_pin_sync.sv ====
/*
  Three-stage synchroniser for a pin level; the output changes once the last two stages agree.
  Assumes the pin idles high after reset.
*/
`default_nettype none
module fcp_pin_sync
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output var  logic level_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r    <= 1'h1;
      s2_r    <= 1'h1;
      s3_r    <= 1'h1;
      level_r <= 1'h1;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;
    end
  end

  assign level_o = level_r;
endmodule // fcp_pin_sync
`default_nettype wire

// ==== include/fcp_defs.svh ====
/*
  Offsets, field positions, reset values and timing figures of the flash control pin controller.
  Assumes a 100 MHz clock and a bus with byte addresses.
*/
`ifndef FCP_DEFS_SVH
`define FCP_DEFS_SVH

`define FCP_CLK_PERIOD_NS            10
`define FCP_RESET_LOW_MIN_NS         500
`define FCP_RESET_RECOVERY_NS        50
`define FCP_BUSY_RELEASE_RECOVERY_NS 20
`define FCP_MIN_CYC(ns) ((((ns) + `FCP_CLK_PERIOD_NS - 1) / `FCP_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `FCP_CLK_PERIOD_NS - 1) / `FCP_CLK_PERIOD_NS))

`define FCP_ADR_CTRL   4'h0
`define FCP_ADR_STATUS 4'h4

`define FCP_CTRL_RST_REQ   0
`define FCP_CTRL_PROT_LSB  1
`define FCP_CTRL_PROT_MSB  2
`define FCP_CTRL_WIDE      3

`define FCP_STAT_BUSY      0
`define FCP_STAT_READY     1
`define FCP_STAT_IN_RESET  2
`define FCP_STAT_PROT_LSB  3
`define FCP_STAT_PROT_MSB  4
`define FCP_STAT_REFUSED   5

`define FCP_RST_WIDE       1'h1

`endif

// ==== include/fcp_pkg.sv ====
/*
  Types of the flash control pin controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package fcp_pkg;
  typedef enum logic [1:0] {
    FCP_PROT_LOW   = 2'h0,
    FCP_PROT_HIGH  = 2'h1,
    FCP_PROT_ACCEL = 2'h2
  } fcp_prot_e;

  typedef enum logic [1:0] {
    FCP_ST_RESET_LOW  = 2'h0,
    FCP_ST_RECOVER    = 2'h1,
    FCP_ST_WAIT_READY = 2'h2,
    FCP_ST_READY      = 2'h3
  } fcp_state_e;
endpackage
`default_nettype wire

// ==== tb/fcp_ctrl_tb.sv ====
/*
  Self-checking bench of the flash control pin controller beside a flash pin model.
  Assumes the register map of fcp_defs.svh and one 100 MHz clock.
*/
`include "fcp_defs.svh"
`default_nettype none
module fcp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, prog = 1'b0, ce_n = 1'b0, lockout = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd, dat;
  logic        ack, pin_n, wide, ready, line, misuse;
  logic [1:0]  lvl;
  int          bad_count = 0, comparisons = 0, low_run = 0, pulse_w = 0;
  initial forever #5 clk_i = ~clk_i;
  fcp_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
    .busy_open_drain_out_i(line), .hard_reset_pin_n_o(pin_n), .accel_voltage_level_o(lvl),
    .width_select_o(wide), .device_ready_o(ready));
  fcp_flash_model flash (.clk_i(clk_i), .rst_pin_n_i(pin_n), .level_i(lvl), .prog_i(prog),
    .ce_n_i(ce_n), .lockout_i(lockout),
    .busy_line_o(line), .misuse_o(misuse));
  // Width of the last low pulse on the reset pin.
  always @(posedge clk_i)
  begin
    if (pin_n === 1'b0)
      low_run <= low_run + 1;
    else if (low_run != 0)
    begin
      pulse_w <= low_run;
      low_run <= 0;
    end
  end
  task automatic report_and_stop;
    $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic wait_on(input logic want, input int lim, output int n);
    n = 0;
    while (ready !== want && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim)
    begin
      bad_count++;
      $display("Error at %0t: wait timed out", $time);
      report_and_stop();
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    chk(n < 20, 1);
    if (n >= 20)
      report_and_stop();
  endtask
  task automatic t_boot(input int lo, input int hi);
    int n;
    n = 0;
    while (pin_n !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300)
    begin
      bad_count++;
      $display("Error at %0t: reset pin never released", $time);
      report_and_stop();
    end
    wait_on(1'b1, 300, n);
    chk(n > 20 && n < 32, 1);
    chk(line, 1);
    chk(pulse_w >= lo && pulse_w <= hi, 1);
    wb(0, `FCP_ADR_STATUS, 32'h0, 4'hF);
    chk(rd, 32'hA);
  endtask
  task automatic t_levels;
    logic [1:0] req [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h1};
    logic [1:0] want [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h1};
    for (int i = 0; i < 5; i++)
    begin
      wb(1, `FCP_ADR_CTRL, {28'h0, 1'b1, req[i], 1'b0}, 4'h1);
      repeat (3) @(posedge clk_i);
      chk(lvl, want[i]);
      wb(0, `FCP_ADR_STATUS, 32'h0, 4'hF);
      chk(rd[4:3], want[i]);
    end
  endtask
  task automatic t_width_bus;
    wb(1, `FCP_ADR_CTRL, 32'h2, 4'h1);
    repeat (3) @(posedge clk_i);
    chk(wide, 0);
    wb(1, `FCP_ADR_CTRL, 32'h0, 4'h0);
    wb(0, 4'h8, 32'h0, 4'hF);
    chk(rd, 0);
    wb(0, `FCP_ADR_CTRL, 32'h0, 4'hF);
    chk(rd, 32'h2);
    wb(1, `FCP_ADR_CTRL, 32'hA, 4'h1);
    repeat (3) @(posedge clk_i);
    chk(wide, 1);
  endtask
  task automatic t_refuse;
    int n;
    prog <= 1'b1;
    @(posedge clk_i);
    prog <= 1'b0;
    wait_on(1'b0, 20, n);
    chk(line, 0);
    wb(1, `FCP_ADR_CTRL, 32'hC, 4'h1);
    repeat (3) @(posedge clk_i);
    chk(lvl, 2'h1);
    wb(0, `FCP_ADR_STATUS, 32'h0, 4'hF);
    chk(rd[`FCP_STAT_REFUSED], 1);
    wait_on(1'b1, 100, n);
    repeat (3) @(posedge clk_i);
    chk(lvl, 2'h2);
    wb(1, `FCP_ADR_STATUS, 32'h20, 4'h1);
    wb(0, `FCP_ADR_STATUS, 32'h0, 4'hF);
    chk(rd[`FCP_STAT_REFUSED], 0);
    wb(1, `FCP_ADR_CTRL, 32'hA, 4'h1);
  endtask
  task automatic t_lockout;
    int n;
    ce_n <= 1'b1;
    prog <= 1'b1;
    @(posedge clk_i);
    prog <= 1'b0;
    ce_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(ready, 1);
    lockout <= 1'b1;
    prog <= 1'b1;
    @(posedge clk_i);
    prog <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(ready, 1);
    lockout <= 1'b0;
    prog <= 1'b1;
    @(posedge clk_i);
    prog <= 1'b0;
    wait_on(1'b0, 20, n);
    lockout <= 1'b1;
    @(posedge clk_i);
    lockout <= 1'b0;
    wait_on(1'b1, 40, n);
    chk(n < 12, 1);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    chk(pin_n, 0);
    chk(lvl, 2'h1);
    chk(ready, 0);
    rst_i <= 1'b0;
    t_boot(50, 60);
    t_width_bus();
    t_levels();
    t_refuse();
    t_lockout();
    wb(1, `FCP_ADR_CTRL, 32'hB, 4'h1);
    chk(pin_n, 0);
    t_boot(50, 51);
    chk(misuse, 0);
    report_and_stop();
  end
endmodule // fcp_ctrl_tb
`default_nettype wire

// ==== tb/fcp_flash_model.sv ====
/*
  Flash control-pin model: busy line with pull-up, busy after boot and during a program.
  A program is ignored while deselected or locked out, and a lockout aborts a running one.
  Assumes it shares the controller's clock.
*/
`default_nettype none
module fcp_flash_model
#(
  parameter int BOOT = 20,
  parameter int PROG = 30
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_pin_n_i,
  input  wire logic [1:0] level_i,
  input  wire logic       prog_i,
  input  wire logic       ce_n_i,
  input  wire logic       lockout_i,
  output var  logic       busy_line_o,
  output var  logic       misuse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         left_r = 0;
  logic       rp_q   = 1'b0;
  logic [1:0] lvl_q  = 2'h1;
  logic       bad_r  = 1'b0;
  always @(posedge clk_i)
  begin
    rp_q <= rst_pin_n_i;
    lvl_q <= level_i;
    if (!rst_pin_n_i)
      left_r <= 0;
    else if (!rp_q)
      left_r <= BOOT;
    else if (lockout_i)
      left_r <= 0;
    else if (prog_i && !ce_n_i && left_r == 0)
      left_r <= PROG;
    else if (left_r != 0)
      left_r <= left_r - 1;
    if (level_i == 2'h2 && lvl_q != 2'h2 && (left_r != 0 || !rst_pin_n_i))
      bad_r <= 1'b1;
  end
  // The line floats high unless this device pulls it low.
  assign busy_line_o = (left_r == 0);
  assign misuse_o    = bad_r;
endmodule // fcp_flash_model
`default_nettype wire
